// ---- design/bpgc_pkg.sv ----
// shared constants and types for the bit error rate pattern generator and checker
package bpgc_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PAT_CTRL = 8'h70;
    localparam logic [7:0] OFS_TX_CTRL = 8'h72;
    localparam logic [7:0] OFS_PAT_LO = 8'h74;
    localparam logic [7:0] OFS_PAT_HI = 8'h76;
    localparam logic [7:0] OFS_BC_LO = 8'h78;
    localparam logic [7:0] OFS_BC_HI = 8'h7a;
    localparam logic [7:0] OFS_EC_LO = 8'h7c;
    localparam logic [7:0] OFS_EC_HI = 8'h7e;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_FORCE_A = 0;
    localparam int BIT_SNAP = 1;
    localparam int PCODE_LSB = 2;
    localparam int BIT_RXINV = 5;
    localparam int BIT_TXINV = 6;
    localparam int BIT_BANK = 7;
    localparam int RLEN_LSB = 8;
    localparam int BIT_IE_OVF = 13;
    localparam int BIT_IE_BED = 14;
    localparam int BIT_IE_SYNC = 15;
    localparam int BIT_TXLOAD = 0;
    localparam int BIT_ONE_ERR = 4;
    localparam int ERATE_LSB = 5;
    localparam int AWC_LSB = 8;
    localparam int ST_SYNC = 0;
    localparam int ST_BECO = 1;
    localparam int ST_BBCO = 2;
    localparam int ST_BED = 3;
    localparam int ST_RLOS = 4;
    localparam int ST_RA0 = 5;
    localparam int ST_RA1 = 6;
    localparam int ST_SCHG = 7;

    // ----------------------------------------------------------------
    // writable bits and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL0_WMASK = 16'hefff;
    localparam logic [15:0] CTRL1_WMASK = 16'hfff1;
    localparam logic [15:0] REG_RST = 16'h0000;

    // ----------------------------------------------------------------
    // counts
    // ----------------------------------------------------------------
    localparam logic [5:0] SYNC_LAST = 6'd31;
    localparam logic [5:0] LOSS_WIN_LAST = 6'd63;
    localparam logic [2:0] LOSS_ERRS = 3'd6;
    localparam logic [4:0] RUN_ALL = 5'd31;
    localparam int REP_BASE = 17;
    localparam logic [23:0] ERR_P10 = 24'd10;
    localparam logic [23:0] ERR_P100 = 24'd100;
    localparam logic [23:0] ERR_P1K = 24'd1000;

    typedef enum logic [3:0] {
        MODE_PRBS7, MODE_PRBS9, MODE_PRBS11, MODE_PRBS15, MODE_PRBS20,
        MODE_QRSS, MODE_PRBS23, MODE_REPEAT, MODE_ALTWORD, MODE_ILLEGAL
    } bpgc_mode_e;

endpackage : bpgc_pkg

// ---- design/bpgc_pat_engine.sv ----
// one step of the pattern sequence, shared by generator and checker
`timescale 1ns/1ps
module bpgc_pat_engine import bpgc_pkg::*; #(
    parameter int W = 32
) (
    input bpgc_mode_e mode,
    input wire logic [3:0] lenCode,
    input wire logic [15:0] patLow,
    input wire logic [15:0] patHigh,
    input wire logic [7:0] awCount,
    input wire logic [W-1:0] stIn,
    input wire logic [3:0] idxIn,
    input wire logic [7:0] cntIn,
    input wire logic selIn,
    input wire logic load,
    input wire logic loadSkip,
    input wire logic useIn,
    input wire logic inBit,
    output logic bitOut,
    output logic [W-1:0] stOut,
    output logic [3:0] idxOut,
    output logic [7:0] cntOut,
    output logic selOut
);
    always_comb begin
        logic raw;
        logic fill;
        int pos;
        raw = 1'b0;
        fill = 1'b0;
        pos = REP_BASE + int'(lenCode) - 1; // RULE7
        stOut = stIn;
        idxOut = idxIn;
        cntOut = cntIn;
        selOut = selIn;
        case (mode)
            MODE_PRBS7: raw = stIn[6] ^ stIn[5]; // RULE1
            MODE_PRBS9: raw = stIn[8] ^ stIn[4]; // RULE3
            MODE_PRBS11: raw = stIn[10] ^ stIn[8]; // RULE1
            MODE_PRBS15: raw = stIn[14] ^ stIn[13]; // RULE1
            MODE_PRBS20, MODE_QRSS: raw = stIn[19] ^ stIn[16]; // RULE2 RULE3
            MODE_PRBS23: raw = stIn[22] ^ stIn[17]; // RULE3
            MODE_REPEAT: raw = stIn[0]; // RULE16
            MODE_ALTWORD: raw = selIn ? patHigh[idxIn] : patLow[idxIn]; // RULE16
            default: raw = 1'b0;
        endcase
        fill = useIn ? inBit : raw;
        // zero runs are capped at fourteen by forcing a one
        bitOut = raw | ((mode == MODE_QRSS) && (stIn[13:0] == 14'h0)); // RULE2
        case (mode)
            MODE_REPEAT: begin
                // rotate inside the programmed length only
                stOut = stIn >> 1; // RULE7
                stOut[pos] = fill;
            end
            MODE_ALTWORD: begin
                idxOut = idxIn + 4'h1;
                if (idxIn == 4'hf) begin
                    if (cntIn == awCount) begin // RULE14
                        cntOut = 8'h0;
                        selOut = ~selIn;
                    end else begin
                        cntOut = cntIn + 8'h1;
                    end
                end
            end
            MODE_ILLEGAL: stOut = stIn;
            default: stOut = {stIn[W-2:0], fill};
        endcase
        if (load) begin
            stOut = {patHigh, patLow}; // RULE15
            idxOut = 4'h0;
            cntOut = (loadSkip && awCount != 8'h0) ? 8'h1 : 8'h0;
            selOut = loadSkip && awCount == 8'h0;
        end
    end
endmodule : bpgc_pat_engine

// ---- design/bpgc_bert_top.sv ----
// bit error rate tester: pattern generator, pattern checker, counters and registers
// Notes on behaviour
// RULE1 - bank 0 codes: PRBS7/11/15, repeat, alternating
// RULE2 - bank 0 code 3 is QRSS
// RULE3 - bank 1 codes: PRBS9, PRBS20, PRBS23 only
// RULE4 - bit 7 picks the pattern bank
// RULE5 - receive invert flips incoming bits
// RULE6 - transmit invert flips outgoing bits
// RULE7 - repeat length is 17 plus code
// RULE8 - overflow interrupt gated by its enable
// RULE9 - bit error interrupt gated by enable
// RULE10 - sync change interrupt gated by enable
// RULE11 - rising load bit reloads the generator
// RULE12 - rising single error bit corrupts one bit (a rate error in the same cycle cancels it, leaving the bit intact)
// RULE13 - rate code inserts errors every 10^n bits (a single error in the same cycle cancels that one)
// RULE14 - alternating words each sent count plus one
// RULE15 - pattern value loaded before use
// RULE16 - least significant pattern bit goes first
// RULE17 - software loads all ones for PRBS
// RULE18 - software repeats short patterns to fill
// RULE19 - software puts the two words apart
// RULE20 - rising force_a bit restarts the checker
// RULE21 - rising snapshot bit copies, clears counts
// RULE22 - sync after 32 matches, lost at 6/64
// RULE23 - control edges found against previous value
// RULE24 - illegal code: zeros out, never in sync
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module bpgc_bert_top import bpgc_pkg::*; #(
    parameter logic [23:0] ERR_P10K = 24'd10000,
    parameter logic [23:0] ERR_P100K = 24'd100000,
    parameter logic [23:0] ERR_P1M = 24'd1000000,
    parameter logic [23:0] ERR_P10M = 24'd10000000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    output logic txData,
    input wire logic rxData,
    output logic syncOut,
    output logic irqOut
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ctrl0;
        logic [15:0] ctrl1;
        logic [15:0] patLo;
        logic [15:0] patHi;
        logic [15:0] rdData;
        logic prevResync;
        logic prevSnap;
        logic prevTxLoad;
        logic prevOneErr;
        logic [31:0] gSt;
        logic [3:0] gIdx;
        logic [7:0] gCnt;
        logic gSel;
        logic [23:0] rateCnt;
        logic txBit;
        logic [31:0] cSt;
        logic [3:0] cIdx;
        logic [7:0] cCnt;
        logic cSel;
        logic [31:0] hist;
        logic inSync;
        logic [5:0] matchCnt;
        logic [5:0] winCnt;
        logic [2:0] winErr;
        logic [31:0] bitCnt;
        logic [23:0] errCnt;
        logic [31:0] bcSnap;
        logic [23:0] ecSnap;
        logic beco;
        logic bbco;
        logic bed;
        logic rlos;
        logic schg;
        logic runVal;
        logic [4:0] runLen;
        logic irq;
    } bpgc_state_s;

    bpgc_state_s st_r;
    bpgc_state_s st_nxt;

    bpgc_mode_e curMode;
    logic illegal;
    logic resyncP;
    logic snapP;
    logic txLoadP;
    logic oneErrP;
    logic rateHit;
    logic [2:0] erate;
    logic [23:0] ratePeriod;
    logic rxBit;
    logic gBit;
    logic cBit;
    logic bitErr;
    logic altLock;
    logic [31:0] histN;
    logic [31:0] gStN;
    logic [31:0] cStN;
    logic [3:0] gIdxN;
    logic [3:0] cIdxN;
    logic [7:0] gCntN;
    logic [7:0] cCntN;
    logic gSelN;
    logic cSelN;

    function automatic bpgc_mode_e decodeMode(input logic bank, input logic [2:0] code);
        bpgc_mode_e m;
        m = MODE_ILLEGAL;
        if (!bank) begin
            case (code)
                3'h0: m = MODE_PRBS7;
                3'h1: m = MODE_PRBS11;
                3'h2: m = MODE_PRBS15;
                3'h3: m = MODE_QRSS;
                3'h4: m = MODE_REPEAT;
                3'h5: m = MODE_ALTWORD;
                default: m = MODE_ILLEGAL;
            endcase
        end else begin
            case (code)
                3'h0: m = MODE_PRBS9;
                3'h1: m = MODE_PRBS20;
                3'h2: m = MODE_PRBS23;
                default: m = MODE_ILLEGAL;
            endcase
        end
        return m;
    endfunction : decodeMode

    // ----------------------------------------------------------------
    // mode decode and control edges
    // ----------------------------------------------------------------
    assign curMode = decodeMode(st_r.ctrl0[BIT_BANK], st_r.ctrl0[PCODE_LSB +: 3]); // RULE1 RULE3 RULE4
    assign illegal = curMode == MODE_ILLEGAL;
    assign resyncP = st_r.ctrl0[BIT_FORCE_A] & ~st_r.prevResync; // RULE20 RULE23
    assign snapP = st_r.ctrl0[BIT_SNAP] & ~st_r.prevSnap; // RULE21 RULE23
    assign txLoadP = st_r.ctrl1[BIT_TXLOAD] & ~st_r.prevTxLoad; // RULE11 RULE23
    assign oneErrP = st_r.ctrl1[BIT_ONE_ERR] & ~st_r.prevOneErr; // RULE12 RULE23
    assign erate = st_r.ctrl1[ERATE_LSB +: 3];

    always_comb begin
        case (erate)
            3'h1: ratePeriod = ERR_P10;
            3'h2: ratePeriod = ERR_P100;
            3'h3: ratePeriod = ERR_P1K;
            3'h4: ratePeriod = ERR_P10K;
            3'h5: ratePeriod = ERR_P100K;
            3'h6: ratePeriod = ERR_P1M;
            3'h7: ratePeriod = ERR_P10M;
            default: ratePeriod = 24'h0;
        endcase
    end

    assign rateHit = (erate != 3'h0) && (st_r.rateCnt == ratePeriod - 24'h1); // RULE13
    assign rxBit = rxData ^ st_r.ctrl0[BIT_RXINV]; // RULE5
    assign bitErr = rxBit ^ cBit;
    assign histN = {rxBit, st_r.hist[31:1]};
    // the high word then the low word just arrived: phase is known
    assign altLock = (curMode == MODE_ALTWORD) && !st_r.inSync && (histN == {st_r.patLo, st_r.patHi});

    // ----------------------------------------------------------------
    // pattern engines
    // ----------------------------------------------------------------
    bpgc_pat_engine #(.W(32)) u_gen (
        .mode(curMode),
        .lenCode(st_r.ctrl0[RLEN_LSB +: 4]),
        .patLow(st_r.patLo),
        .patHigh(st_r.patHi),
        .awCount(st_r.ctrl1[AWC_LSB +: 8]),
        .stIn(st_r.gSt),
        .idxIn(st_r.gIdx),
        .cntIn(st_r.gCnt),
        .selIn(st_r.gSel),
        .load(txLoadP),
        .loadSkip(1'b0),
        .useIn(1'b0),
        .inBit(1'b0),
        .bitOut(gBit),
        .stOut(gStN),
        .idxOut(gIdxN),
        .cntOut(gCntN),
        .selOut(gSelN)
    );

    // while searching the checker feeds on received bits, in sync it runs free
    bpgc_pat_engine #(.W(32)) u_chk (
        .mode(curMode),
        .lenCode(st_r.ctrl0[RLEN_LSB +: 4]),
        .patLow(st_r.patLo),
        .patHigh(st_r.patHi),
        .awCount(st_r.ctrl1[AWC_LSB +: 8]),
        .stIn(st_r.cSt),
        .idxIn(st_r.cIdx),
        .cntIn(st_r.cCnt),
        .selIn(st_r.cSel),
        .load(resyncP | altLock),
        .loadSkip(altLock),
        .useIn(!st_r.inSync),
        .inBit(rxBit),
        .bitOut(cBit),
        .stOut(cStN),
        .idxOut(cIdxN),
        .cntOut(cCntN),
        .selOut(cSelN)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] errs;
        logic enter;
        errs = st_r.winErr + {2'b00, bitErr};
        enter = 1'b0;
        st_nxt = st_r;
        st_nxt.rdData = 16'h0;
        st_nxt.prevResync = st_r.ctrl0[BIT_FORCE_A];
        st_nxt.prevSnap = st_r.ctrl0[BIT_SNAP];
        st_nxt.prevTxLoad = st_r.ctrl1[BIT_TXLOAD];
        st_nxt.prevOneErr = st_r.ctrl1[BIT_ONE_ERR];
        if (regWr) begin
            case (regAddr)
                OFS_PAT_CTRL: st_nxt.ctrl0 = regWrData & CTRL0_WMASK;
                OFS_TX_CTRL: st_nxt.ctrl1 = regWrData & CTRL1_WMASK;
                OFS_PAT_LO: st_nxt.patLo = regWrData; // RULE15
                OFS_PAT_HI: st_nxt.patHi = regWrData; // RULE15
                default: st_nxt.ctrl0 = st_r.ctrl0;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                OFS_PAT_CTRL: st_nxt.rdData = st_r.ctrl0;
                OFS_TX_CTRL: st_nxt.rdData = st_r.ctrl1;
                OFS_PAT_LO: st_nxt.rdData = st_r.patLo;
                OFS_PAT_HI: st_nxt.rdData = st_r.patHi;
                OFS_BC_LO: st_nxt.rdData = st_r.bcSnap[15:0];
                OFS_BC_HI: st_nxt.rdData = st_r.bcSnap[31:16];
                OFS_EC_LO: begin
                    st_nxt.rdData = {st_r.ecSnap[7:0], st_r.schg, st_r.runVal && st_r.runLen == RUN_ALL,
                        !st_r.runVal && st_r.runLen == RUN_ALL, st_r.rlos, st_r.bed, st_r.bbco,
                        st_r.beco, st_r.inSync};
                    // flags clear on read, rlos only while in sync; a same-cycle event below wins
                    st_nxt.beco = 1'b0;
                    st_nxt.bbco = 1'b0;
                    st_nxt.bed = 1'b0;
                    st_nxt.schg = 1'b0;
                    st_nxt.rlos = st_r.rlos && !st_r.inSync;
                end
                OFS_EC_HI: st_nxt.rdData = st_r.ecSnap[23:8];
                default: st_nxt.rdData = 16'h0;
            endcase
        end

        // generator
        st_nxt.gSt = gStN;
        st_nxt.gIdx = gIdxN;
        st_nxt.gCnt = gCntN;
        st_nxt.gSel = gSelN;
        st_nxt.rateCnt = (erate == 3'h0 || rateHit) ? 24'h0 : st_r.rateCnt + 24'h1; // RULE13
        if (illegal) begin
            st_nxt.txBit = 1'b0; // RULE24
        end else begin
            st_nxt.txBit = gBit ^ st_r.ctrl0[BIT_TXINV] ^ oneErrP ^ rateHit; // RULE6 RULE12 RULE13
        end

        // checker
        st_nxt.cSt = cStN;
        st_nxt.cIdx = cIdxN;
        st_nxt.cCnt = cCntN;
        st_nxt.cSel = cSelN;
        st_nxt.hist = histN;
        if (illegal || resyncP) begin
            st_nxt.inSync = 1'b0; // RULE20 RULE24
            st_nxt.matchCnt = 6'h0;
            st_nxt.winCnt = 6'h0;
            st_nxt.winErr = 3'h0;
            st_nxt.rlos = 1'b1;
        end else if (!st_r.inSync) begin
            if (bitErr || altLock) begin
                st_nxt.matchCnt = 6'h0;
            end else if (st_r.matchCnt == SYNC_LAST) begin
                st_nxt.inSync = 1'b1; // RULE22
                st_nxt.matchCnt = 6'h0;
                enter = 1'b1;
            end else begin
                st_nxt.matchCnt = st_r.matchCnt + 6'h1;
            end
        end else if (errs >= LOSS_ERRS) begin
            st_nxt.inSync = 1'b0; // RULE22
            st_nxt.winCnt = 6'h0;
            st_nxt.winErr = 3'h0;
            st_nxt.rlos = 1'b1;
        end else if (st_r.winCnt == LOSS_WIN_LAST) begin
            st_nxt.winCnt = 6'h0;
            st_nxt.winErr = 3'h0;
        end else begin
            st_nxt.winCnt = st_r.winCnt + 6'h1;
            st_nxt.winErr = errs;
        end
        if (enter || st_nxt.inSync != st_r.inSync) begin
            st_nxt.schg = 1'b1; // RULE10
        end

        // counters saturate and never roll over
        if (st_r.bitCnt != 32'hffff_ffff) begin
            st_nxt.bitCnt = st_r.bitCnt + 32'h1;
            st_nxt.bbco = st_nxt.bbco | (st_r.bitCnt == 32'hffff_fffe); // RULE8
        end
        if (st_r.inSync && bitErr) begin
            st_nxt.bed = 1'b1; // RULE9
            if (st_r.errCnt != 24'hff_ffff) begin
                st_nxt.errCnt = st_r.errCnt + 24'h1;
                st_nxt.beco = st_nxt.beco | (st_r.errCnt == 24'hff_fffe); // RULE8
            end
        end
        if (snapP) begin
            st_nxt.bcSnap = st_r.bitCnt; // RULE21
            st_nxt.ecSnap = st_r.errCnt;
            st_nxt.bitCnt = 32'h0;
            st_nxt.errCnt = 24'h0;
        end

        // run detection for the all-zeros and all-ones flags
        if (rxBit == st_r.runVal) begin
            st_nxt.runLen = (st_r.runLen == RUN_ALL) ? RUN_ALL : st_r.runLen + 5'h1;
        end else begin
            st_nxt.runVal = rxBit;
            st_nxt.runLen = 5'h1;
        end

        // enables taken from the next value so a fresh write and the flags line up
        st_nxt.irq = (st_nxt.ctrl0[BIT_IE_OVF] & (st_nxt.beco | st_nxt.bbco)) // RULE8
            | (st_nxt.ctrl0[BIT_IE_BED] & st_nxt.bed) // RULE9
            | (st_nxt.ctrl0[BIT_IE_SYNC] & st_nxt.schg); // RULE10
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign txData = st_r.txBit;
    assign syncOut = st_r.inSync;
    assign irqOut = st_r.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_illegal_tx;
        illegal |=> !txData;
    endproperty
    a_illegal_tx: assert property (p_illegal_tx) else $error("illegal pattern code did not give zeros"); // RULE24

    property p_illegal_sync;
        illegal |=> !syncOut;
    endproperty
    a_illegal_sync: assert property (p_illegal_sync) else $error("checker in sync on illegal code"); // RULE24

    property p_bank1_top;
        st_r.ctrl0[BIT_BANK] && st_r.ctrl0[PCODE_LSB +: 3] > 3'h2 |-> illegal;
    endproperty
    a_bank1_top: assert property (p_bank1_top) else $error("bank 1 upper code not illegal"); // RULE3 RULE4

    property p_tx_invert;
        !illegal && !oneErrP && !rateHit |=> txData == ($past(gBit) ^ $past(st_r.ctrl0[BIT_TXINV]));
    endproperty
    a_tx_invert: assert property (p_tx_invert) else $error("transmit bit wrong for invert setting"); // RULE6

    property p_single_err;
        oneErrP && !illegal && !rateHit |=> txData != ($past(gBit) ^ $past(st_r.ctrl0[BIT_TXINV]));
    endproperty
    a_single_err: assert property (p_single_err) else $error("single error not inserted"); // RULE12

    property p_rate_ten;
        rateHit && erate == 3'h1 |-> st_r.rateCnt == 24'd9;
    endproperty
    a_rate_ten: assert property (p_rate_ten) else $error("error rate 1 in 10 misplaced"); // RULE13

    property p_sync_enter;
        !st_r.inSync && st_r.matchCnt == SYNC_LAST && !bitErr && !illegal && !resyncP && !altLock
            |=> syncOut ##0 st_r.schg;
    endproperty
    a_sync_enter: assert property (p_sync_enter) else $error("sync not declared after 32 matches"); // RULE22 RULE10

    property p_sync_loss;
        st_r.inSync && st_r.winErr == 3'd5 && bitErr |=> !syncOut ##0 st_r.rlos;
    endproperty
    a_sync_loss: assert property (p_sync_loss) else $error("sync kept after sixth error"); // RULE22

    property p_force_a;
        resyncP |=> !syncOut ##1 !syncOut;
    endproperty
    a_force_a: assert property (p_force_a) else $error("force_a did not restart search"); // RULE20

    property p_snapshot;
        snapP |=> st_r.bcSnap == $past(st_r.bitCnt) && st_r.bitCnt == 32'h0;
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("counter snapshot wrong"); // RULE21

    property p_bed_irq;
        st_r.bed && st_r.ctrl0[BIT_IE_BED] |-> irqOut;
    endproperty
    a_bed_irq: assert property (p_bed_irq) else $error("bit error interrupt missing"); // RULE9

    property p_irq_masked;
        !st_r.ctrl0[BIT_IE_OVF] && !st_r.ctrl0[BIT_IE_BED] && !st_r.ctrl0[BIT_IE_SYNC] |-> !irqOut;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while all masked"); // RULE8 RULE9 RULE10

    property p_alt_flip;
        curMode == MODE_ALTWORD && !txLoadP && st_r.gIdx == 4'hf && st_r.gCnt == st_r.ctrl1[AWC_LSB +: 8]
            |=> st_r.gSel != $past(st_r.gSel) && st_r.gCnt == 8'h0;
    endproperty
    a_alt_flip: assert property (p_alt_flip) else $error("alternating word did not flip"); // RULE14

    property p_load_lsb;
        txLoadP && curMode == MODE_REPEAT |=> st_r.gSt == {$past(st_r.patHi), $past(st_r.patLo)};
    endproperty
    a_load_lsb: assert property (p_load_lsb) else $error("pattern load did not take the words"); // RULE11 RULE16

    c_sync: cover property (!st_r.inSync ##1 st_r.inSync);
    c_alt_lock: cover property (altLock);
    c_rate: cover property (rateHit && erate == 3'h1);
    c_snap: cover property (snapP && st_r.errCnt != 24'h0);

endmodule : bpgc_bert_top

// ---- verification/bpgc_far_end.sv ----
// far-end datapath model: loops the transmitted stream back
`timescale 1ns/1ps
module bpgc_far_end (
    input wire logic clk_sys,
    input wire logic txBit,
    input wire logic flip,
    output logic rxBit
);
    // one cycle of line delay; flip models an inverting far end
    always_ff @(posedge clk_sys) begin
        rxBit <= txBit ^ flip;
    end
endmodule : bpgc_far_end

// ---- verification/testbench.sv ----
// self-checking bench: registers, generated stream and looped-back checker
`timescale 1ns/1ps
module testbench;
    import bpgc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic flip = 1'b0;
    logic [15:0] regRdData, rdv;
    logic txData, rxData, syncOut, irqOut;
    logic [63:0] e;
    logic [31:0] pat = 32'h5ad6b5ad;
    logic [15:0] codes [7] = '{16'h0000, 16'h0004, 16'h0008, 16'h000c, 16'h0080, 16'h0084, 16'h0088};
    int errTotal = 0;
    int compares = 0;
    always #10 clk_sys = ~clk_sys;
    bpgc_bert_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txData(txData), .rxData(rxData),
        .syncOut(syncOut), .irqOut(irqOut));
    bpgc_far_end far (.clk_sys(clk_sys), .txBit(txData), .flip(flip), .rxBit(rxData));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrapUp;
        $display("compares %0d, errTotal %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrapUp
    // ----------------------------------------
    // bus cycles and scenario helpers
    // ----------------------------------------
    // strobe drops at the taking edge; one idle cycle keeps drivers single per step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 rdv = regRdData;
        @(posedge clk_sys);
    endtask : rd
    // load taken at edge E, first bit of the new pattern at E+2
    task automatic txSeq(input logic [15:0] c0, input logic [15:0] c1, input logic [63:0] x);
        wr(OFS_TX_CTRL, 16'h0000);
        wr(OFS_PAT_CTRL, c0);
        wr(OFS_TX_CTRL, c1);
        for (int i = 0; i < 64; i++) begin
            @(posedge clk_sys);
            #1 check("txData", 16'(txData), 16'(x[i]));
        end
        @(posedge clk_sys);
    endtask : txSeq
    task automatic start(input logic [15:0] c);
        wr(OFS_TX_CTRL, 16'h0000);
        wr(OFS_PAT_CTRL, c);
        wr(OFS_TX_CTRL, 16'h0001);
        wr(OFS_PAT_CTRL, c | 16'h0001);
        repeat (4) @(posedge clk_sys);
    endtask : start
    task automatic waitSync(input logic lvl, input logic irqE);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (syncOut !== lvl && n < 200);
        check("syncOut", 16'(syncOut), 16'(lvl));
        repeat (2) @(negedge clk_sys);
        check("irqOut", 16'(irqOut), 16'(irqE));
        @(posedge clk_sys);
    endtask : waitSync
    initial begin
        #200000;
        errTotal++;
        wrapUp();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(OFS_PAT_HI);
        check("patHi", rdv, REG_RST);
        wr(OFS_PAT_CTRL, 16'hffff);
        wr(OFS_TX_CTRL, 16'hffff);
        rd(OFS_PAT_CTRL);
        check("ctrl0", rdv, CTRL0_WMASK);
        rd(OFS_TX_CTRL);
        check("ctrl1", rdv, CTRL1_WMASK);
        rd(8'h80);
        check("unmapped", rdv, 16'h0000);
        wr(OFS_PAT_LO, 16'hb5ad);
        wr(OFS_PAT_HI, 16'h5ad6);
        for (int i = 0; i < 64; i++)
            e[i] = pat[i % 30];
        txSeq(16'h0d10, 16'h0001, e);
        txSeq(16'h0d50, 16'h0001, ~e);
        txSeq(16'h0d10, 16'h0021, e ^ 64'h0401_0040_1004_0100);
        wr(OFS_PAT_LO, 16'h0000);
        wr(OFS_PAT_HI, 16'h7e7e);
        txSeq(16'h0014, 16'h0101, 64'h7e7e7e7e_00000000);
        txSeq(16'h0018, 16'h0001, 64'h0);
        txSeq(16'h008c, 16'h0001, 64'h0);
        wr(OFS_PAT_LO, 16'hffff);
        wr(OFS_PAT_HI, 16'hffff);
        foreach (codes[k]) begin
            start(codes[k] | 16'h8000);
            waitSync(1'b1, 1'b1);
            rd(OFS_EC_LO);
            check("syncFlag", 16'(rdv[0]), 16'h0001);
        end
        wr(OFS_PAT_CTRL, 16'h00a8);
        waitSync(1'b0, 1'b0);
        flip <= 1'b1;
        start(16'h00a8);
        waitSync(1'b1, 1'b0);
        wr(OFS_PAT_CTRL, 16'h40aa);
        rd(OFS_EC_LO);
        wr(OFS_TX_CTRL, 16'h0011);
        repeat (10) @(posedge clk_sys);
        wr(OFS_PAT_CTRL, 16'h40a8);
        wr(OFS_PAT_CTRL, 16'h40aa);
        waitSync(1'b1, 1'b1);
        rd(OFS_EC_LO);
        check("errCount", 16'(rdv[15:8]), 16'h0001);
        wrapUp();
    end
endmodule : testbench
